// >>> fgc_glyph_ram.sv
// font block store and character generator shared types, plus a flop-based byte store
// assumes one clock; storage has no reset, so contents are undefined until written
//******************************************
// package
//******************************************
package fgc_pkg;
  localparam logic [19:0] FGC_FONT_BASE = 20'ha0000;
  localparam logic [19:0] FGC_BLK_SPAN  = 20'h02000;
  localparam logic [19:0] FGC_FONT_END  = 20'ha8000;
  localparam logic [19:0] FGC_TEXT_BASE = 20'hb8000;
  localparam logic [19:0] FGC_TEXT_END  = 20'hbffff;
  localparam int          FGC_BLK_LSB   = 13;
  localparam int          FGC_CHR_LSB   = 5;
  localparam int          FGC_ROW_SPARE = 4;
  localparam int          FGC_TEXT_AW   = 15;
  localparam int          FGC_GLYPH_AW  = 12;
  localparam logic [1:0]  FGC_SPEC_RST  = 2'h0;
  localparam int          FGC_ATTR_PAGE = 3;
  localparam int          FGC_ROWS8_W   = 3;

  typedef struct packed {
    logic        wr;
    logic [19:0] addr;
    logic [7:0]  data;
  } fgc_hwr_t;

  typedef struct packed {
    logic       req;
    logic [7:0] code;
    logic [7:0] attr;
    logic [3:0] row;
  } fgc_fetch_t;
endpackage

`timescale 1ns/1ps
`default_nettype none
//******************************************
// byte store, one write port, one registered read port
//******************************************
module fgc_byte_ram #(
  parameter int AW = 12,
  parameter int DW = 8
) (
  // clock
  input  wire logic          i_sys_clk,
  // write side
  input  wire logic          i_wr,
  input  wire logic [AW-1:0] i_waddr,
  input  wire logic [DW-1:0] i_wdata,
  // read side
  input  wire logic [AW-1:0] i_raddr,
  output logic      [DW-1:0] o_rdata
);
  generate
    if (AW < 1 || DW < 1) begin : g_bad
      $error("fgc_byte_ram: widths must be positive");
    end
  endgenerate

  logic [DW-1:0] mem [2**AW];

  always_ff @(posedge i_sys_clk) begin
    if (i_wr) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    o_rdata <= mem[i_raddr];
  end
endmodule // fgc_byte_ram
`default_nettype wire

// >>> fgc_font_gen.sv
// loadable font logic: four font blocks, block-specifier copy into two glyph pages, glyph fetch
// assumes host writes and display fetches are on i_sys_clk; the retrace pin is asynchronous
//
// Behaviour
// - text writes land at the upper base and font writes at the lower base of the buffer.
// - the font area is four blocks on successive 8K boundaries, with a reserved span above.
// - four fonts are held but at most two are copied into the generator and shown.
// - a new block selection is only copied into the generator at the start of vertical retrace.
// - only 8x8 and 8x16 cells exist, chosen by the cell-height input from the active mode.
// - font block writes reach the display only after the block is copied into the generator.
// - the generator is two pages of 256 glyphs, page zero for codes 0-255, page one for 256-511.
// - specifier bits 1:0 pick the block copied into page zero; bits above 3 are ignored.
// - specifier bits 3:2 pick the block copied into page one.
// - equal selector pairs copy only page zero and leave a 256-character set.
// - in a 512 set attribute bit 3 picks page one when set and page zero when clear.
// - attribute bit 3 still drives the intensity output whatever page it selects.
`timescale 1ns/1ps
`default_nettype none
module fgc_font_gen
  import fgc_pkg::*;
(
  // clock and reset
  input  wire logic                   i_sys_clk,
  input  wire logic                   i_rst_b,
  // host side
  input  wire fgc_hwr_t               i_host,
  input  wire logic                   i_spec_wr,
  input  wire logic [7:0]             i_spec,
  input  wire logic                   i_vretrace,
  input  wire logic                   i_cell_16,
  // display side
  input  wire fgc_fetch_t             i_fetch,
  output logic [7:0]                  o_glyph,
  output logic                        o_glyph_vld,
  output logic                        o_intense,
  // text area write-through
  output logic                        o_text_wr,
  output logic [FGC_TEXT_AW-1:0]      o_text_addr,
  output logic [7:0]                  o_text_data,
  // status
  output logic                        o_set512,
  output logic                        o_busy
);
  //******************************************
  // reset and retrace synchronisers
  //******************************************
  logic rst_s1_r, rst_b_r;
  logic vr_s1_r, vr_s2_r, vr_d_r;
  logic vr_rise;

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_s1_r <= 1'b0;
      rst_b_r  <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_b_r  <= rst_s1_r;
    end
  end

  always_ff @(posedge i_sys_clk or negedge rst_b_r) begin
    if (!rst_b_r) begin
      vr_s1_r <= 1'b0;
      vr_s2_r <= 1'b0;
      vr_d_r  <= 1'b0;
    end else begin
      vr_s1_r <= i_vretrace;
      vr_s2_r <= vr_s1_r;
      vr_d_r  <= vr_s2_r;
    end
  end

  assign vr_rise = vr_s2_r & ~vr_d_r;

  //******************************************
  // host address decode
  //******************************************
  logic font_hit, text_hit;
  logic [13:0] blk_waddr;

  assign font_hit  = i_host.wr && (i_host.addr >= FGC_FONT_BASE) && (i_host.addr < FGC_FONT_END)
                     && !i_host.addr[FGC_ROW_SPARE];
  assign text_hit  = i_host.wr && (i_host.addr >= FGC_TEXT_BASE) && (i_host.addr <= FGC_TEXT_END);
  // rows 16-31 of each 32-byte slot have no cell to show, so they are dropped
  assign blk_waddr = {i_host.addr[FGC_BLK_LSB+1:FGC_BLK_LSB],
                      i_host.addr[FGC_CHR_LSB+7:FGC_CHR_LSB],
                      i_host.addr[3:0]};

  always_ff @(posedge i_sys_clk or negedge rst_b_r) begin
    if (!rst_b_r) begin
      o_text_wr   <= 1'b0;
      o_text_addr <= '0;
      o_text_data <= 8'h00;
    end else begin
      o_text_wr   <= text_hit;
      o_text_addr <= i_host.addr[FGC_TEXT_AW-1:0];
      o_text_data <= i_host.data;
    end
  end

  //******************************************
  // block specifier and copy engine
  //******************************************
  typedef enum logic [0:0] {FGC_IDLE, FGC_COPY} fgc_state_t;
  fgc_state_t state_r;
  logic [3:0]  spec_r, cpy_spec_r;
  logic        pend_r, cpy_two_r;
  logic [12:0] cnt_r;
  logic        cg_wr_r;
  logic [12:0] cg_waddr_r;
  logic        start, last;
  logic [1:0]  src_blk;
  logic [7:0]  blk_rdata;

  assign start   = (state_r == FGC_IDLE) && pend_r && vr_rise;
  assign last    = cpy_two_r ? (cnt_r == 13'h1fff) : (cnt_r == 13'h0fff);
  assign src_blk = cnt_r[FGC_GLYPH_AW] ? cpy_spec_r[3:2] : cpy_spec_r[1:0];

  // a write in the start cycle stays pending for the next retrace
  always_ff @(posedge i_sys_clk or negedge rst_b_r) begin
    if (!rst_b_r) begin
      spec_r <= {FGC_SPEC_RST, FGC_SPEC_RST};
      pend_r <= 1'b0;
    end else begin
      if (i_spec_wr) begin
        spec_r <= i_spec[3:0];
      end
      pend_r <= i_spec_wr | (pend_r & ~start);
    end
  end

  always_ff @(posedge i_sys_clk or negedge rst_b_r) begin
    if (!rst_b_r) begin
      state_r    <= FGC_IDLE;
      cnt_r      <= '0;
      cpy_spec_r <= 4'h0;
      cpy_two_r  <= 1'b0;
    end else begin
      case (state_r)
        FGC_IDLE: begin
          cnt_r <= '0;
          if (start) begin
            state_r    <= FGC_COPY;
            cpy_spec_r <= spec_r;
            cpy_two_r  <= (spec_r[3:2] != spec_r[1:0]);
          end
        end
        FGC_COPY: begin
          cnt_r <= cnt_r + 13'h0001;
          if (last) begin
            state_r <= FGC_IDLE;
          end
        end
        default: state_r <= FGC_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge rst_b_r) begin
    if (!rst_b_r) begin
      cg_wr_r    <= 1'b0;
      cg_waddr_r <= '0;
      o_set512   <= 1'b0;
      o_busy     <= 1'b0;
    end else begin
      cg_wr_r    <= (state_r == FGC_COPY);
      cg_waddr_r <= cnt_r;
      o_busy     <= (state_r == FGC_COPY) || start;
      if (start) begin
        o_set512 <= (spec_r[3:2] != spec_r[1:0]);
      end
    end
  end

  fgc_byte_ram #(.AW(14), .DW(8)) u_blocks (
    .i_sys_clk (i_sys_clk),
    .i_wr      (font_hit),
    .i_waddr   (blk_waddr),
    .i_wdata   (i_host.data),
    .i_raddr   ({src_blk, cnt_r[FGC_GLYPH_AW-1:0]}),
    .o_rdata   (blk_rdata)
  );

  //******************************************
  // character generator and glyph fetch
  //******************************************
  logic [12:0] cg_raddr;
  logic [3:0]  row_eff;
  logic [7:0]  cg_rdata;
  logic        fvld_r, fint_r;

  assign row_eff  = i_cell_16 ? i_fetch.row : {1'b0, i_fetch.row[FGC_ROWS8_W-1:0]};
  assign cg_raddr = {o_set512 & i_fetch.attr[FGC_ATTR_PAGE], i_fetch.code, row_eff};

  // only the copy engine writes here, which keeps block writes off the screen
  fgc_byte_ram #(.AW(13), .DW(8)) u_chargen (
    .i_sys_clk (i_sys_clk),
    .i_wr      (cg_wr_r),
    .i_waddr   (cg_waddr_r),
    .i_wdata   (blk_rdata),
    .i_raddr   (cg_raddr),
    .o_rdata   (cg_rdata)
  );

  always_ff @(posedge i_sys_clk or negedge rst_b_r) begin
    if (!rst_b_r) begin
      fvld_r      <= 1'b0;
      fint_r      <= 1'b0;
      o_glyph_vld <= 1'b0;
      o_intense   <= 1'b0;
      o_glyph     <= 8'h00;
    end else begin
      fvld_r      <= i_fetch.req;
      fint_r      <= i_fetch.attr[FGC_ATTR_PAGE];
      o_glyph_vld <= fvld_r;
      o_intense   <= fint_r;
      o_glyph     <= fvld_r ? cg_rdata : 8'h00;
    end
  end
endmodule // fgc_font_gen
`default_nettype wire

// >>> fgc_host_model.sv
// host processor model: writes the video buffer, the block specifier and retrace
// assumes the bench clock; drives only just after rising edges
`timescale 1ns/1ps
`default_nettype none
module fgc_host_model
  import fgc_pkg::*;
(
  // clock
  input  wire logic       i_sys_clk,
  // towards the block
  output var  fgc_hwr_t   o_host,
  output var  logic       o_spec_wr,
  output var  logic [7:0] o_spec,
  output var  logic       o_vretrace
);
  initial begin
    o_host = '0;
    o_spec_wr = 1'b0;
    o_spec = 8'h00;
    o_vretrace = 1'b0;
  end
  // released bus shows the inverse, not a stale copy
  task automatic wr(input logic [19:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    #1 o_host = '{1'b1, a, d};
    @(posedge i_sys_clk);
    #1 o_host = '{1'b0, ~a, ~d};
  endtask
  task automatic spec(input logic [7:0] s);
    @(posedge i_sys_clk);
    #1 o_spec_wr = 1'b1;
    o_spec = s;
    @(posedge i_sys_clk);
    #1 o_spec_wr = 1'b0;
    o_spec = ~s;
  endtask
  // swaps are requested, then retrace is raised
  task automatic retrace(input logic v);
    @(posedge i_sys_clk);
    #1 o_vretrace = v;
  endtask
endmodule // fgc_host_model
`default_nettype wire

// >>> fgc_font_gen_monitor.sv
// checker for the font generator top ports
// assumes one clock; bound to every instance of the top module
`timescale 1ns/1ps
`default_nettype none
module fgc_font_gen_monitor
  import fgc_pkg::*;
(
  input wire logic                  i_sys_clk,
  input wire logic                  i_rst_b,
  input wire fgc_hwr_t              i_host,
  input wire fgc_fetch_t            i_fetch,
  input wire logic                  i_vretrace,
  input wire logic [7:0]            o_glyph,
  input wire logic                  o_glyph_vld,
  input wire logic                  o_intense,
  input wire logic                  o_text_wr,
  input wire logic [FGC_TEXT_AW-1:0] o_text_addr,
  input wire logic [7:0]            o_text_data,
  input wire logic                  o_set512,
  input wire logic                  o_busy
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);
  // addresses above the text area are outside the buffer and are not forwarded
  AST_TEXT_FWD: assert property (
    i_host.wr && i_host.addr >= FGC_TEXT_BASE && i_host.addr <= FGC_TEXT_END
      |=> o_text_wr && o_text_addr == $past(i_host.addr[14:0])
      && o_text_data == $past(i_host.data)) else $error("text write not forwarded");
  AST_FONT_QUIET: assert property (
    i_host.wr && i_host.addr < FGC_TEXT_BASE |=> !o_text_wr) else $error("font write forwarded");
  AST_FETCH_LAT: assert property (
    i_fetch.req |-> ##2 o_glyph_vld) else $error("glyph late");
  AST_VLD_CAUSE: assert property (
    o_glyph_vld |-> $past(i_fetch.req, 2)) else $error("glyph without fetch");
  AST_INTENSE: assert property (
    o_glyph_vld |-> o_intense == $past(i_fetch.attr[3], 2)) else $error("intensity wrong");
  AST_GLYPH_IDLE: assert property (
    !o_glyph_vld |-> o_glyph == 8'h00) else $error("glyph not idle");
  AST_RETRACE_START: assert property (
    $rose(o_busy) |-> $past(i_vretrace, 2) || $past(i_vretrace, 3) || $past(i_vretrace, 4)
      || $past(i_vretrace, 5)) else $error("copy without retrace");
  AST_SET512_AT_START: assert property (
    $changed(o_set512) |-> $rose(o_busy)) else $error("set size changed mid copy");
endmodule // fgc_font_gen_monitor
bind fgc_font_gen fgc_font_gen_monitor u_mon (.i_sys_clk, .i_rst_b, .i_host, .i_fetch, .i_vretrace,
  .o_glyph, .o_glyph_vld, .o_intense, .o_text_wr, .o_text_addr, .o_text_data, .o_set512, .o_busy);
`default_nettype wire

// >>> fgc_font_gen_tb.sv
// self-checking bench for the font generator
// assumes the host model and the bound checker
`timescale 1ns/1ps
`default_nettype none
module fgc_font_gen_tb;
  import fgc_pkg::*;
  logic clk = 1'b0, rst_b = 1'b0, cell16 = 1'b1, vret, swr, vld, inten, twr, s512, busy;
  logic [7:0] spc, glyph, tdat;
  logic [14:0] tadr;
  fgc_hwr_t hw;
  fgc_fetch_t fetch = '0;
  int mismatches = 0, n_compared = 0;
  always #5 clk = ~clk;
  fgc_host_model host (.i_sys_clk(clk), .o_host(hw), .o_spec_wr(swr), .o_spec(spc), .o_vretrace(vret));
  fgc_font_gen dut (.i_sys_clk(clk), .i_rst_b(rst_b), .i_host(hw), .i_spec_wr(swr), .i_spec(spc),
    .i_vretrace(vret), .i_cell_16(cell16), .i_fetch(fetch), .o_glyph(glyph), .o_glyph_vld(vld),
    .o_intense(inten), .o_text_wr(twr), .o_text_addr(tadr), .o_text_data(tdat), .o_set512(s512),
    .o_busy(busy));
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    n_compared++;
    if (s !== e) begin
      mismatches++;
      $display("FAIL %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic report_and_stop;
    if (mismatches == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  function automatic logic [7:0] gv(input int b, input int r);
    return 8'((b << 6) | (r << 2) | 1);
  endfunction
  function automatic logic [19:0] fa(input int b, input int r);
    return 20'(FGC_FONT_BASE + FGC_BLK_SPAN * b + 20'h00600 + r);
  endfunction
  task automatic t_copy(input logic [7:0] s, input logic e512);
    int n;
    n = 0;
    host.spec(s);
    repeat (20) @(posedge clk);
    #1 chk("busy_idle", 16'h0000, 16'(busy));
    host.retrace(1'b1);
    while (busy !== 1'b1 && n < 20) begin
      @(posedge clk);
      #1 n++;
    end
    chk("busy_start", 16'h0001, 16'(busy));
    chk("set512", 16'(e512), 16'(s512));
    while (busy !== 1'b0 && n < 9000) begin
      @(posedge clk);
      #1 n++;
    end
    host.retrace(1'b0);
    chk("busy_done", 16'h0000, 16'(busy));
  endtask
  // code 30 is fetched; the answer stands for the cycle after the edge that follows the one that takes the request
  task automatic t_glyph(input logic [7:0] at, input logic [3:0] r, input logic [7:0] e);
    @(posedge clk);
    #1 fetch = '{1'b1, 8'h30, at, r};
    @(posedge clk);
    #1 fetch = '{1'b0, 8'h00, 8'h00, 4'h0};
    @(posedge clk);
    #1 chk("vld", 16'h0001, 16'(vld));
    chk("glyph", 16'(e), 16'(glyph));
    chk("intense", 16'(at[3]), 16'(inten));
  endtask
  initial begin
    repeat (40000) @(posedge clk);
    mismatches++;
    report_and_stop();
  end
  initial begin
    repeat (8) @(posedge clk);
    #1 rst_b = 1'b1;
    repeat (3) @(posedge clk);
    host.wr(20'hb8123, 8'h5a);
    chk("text_wr", 16'h0001, 16'(twr));
    chk("text_addr", 16'h0123, 16'(tadr));
    chk("text_data", 16'h005a, 16'(tdat));
    for (int b = 0; b < 4; b++)
      for (int r = 0; r < 16; r++)
        host.wr(fa(b, r), gv(b, r));
    chk("text_quiet", 16'h0000, 16'(twr));
    t_copy(8'hf1, 1'b1);
    t_glyph(8'h07, 4'h5, gv(1, 5));
    t_glyph(8'h0f, 4'h5, gv(0, 5));
    t_copy(8'h0c, 1'b1);
    t_glyph(8'h07, 4'h2, gv(0, 2));
    t_glyph(8'h0f, 4'h2, gv(3, 2));
    t_copy(8'h0a, 1'b0);
    t_glyph(8'h0f, 4'h4, gv(2, 4));
    host.wr(fa(2, 4), 8'hee);
    t_glyph(8'h07, 4'h4, gv(2, 4));
    @(posedge clk);
    #1 cell16 = 1'b0;
    t_glyph(8'h07, 4'hc, gv(2, 4));
    report_and_stop();
  end
endmodule // fgc_font_gen_tb
`default_nettype wire
